//--- vsrc_pkg.sv
package vsrc_pkg;
   localparam int CNT_W = 12;
   localparam int STAT_W = 16;
   localparam int CLK_EN_BIT = 10;
   localparam logic [CNT_W-1:0] CNT_ZERO = 12'h000;
   localparam logic [CNT_W-1:0] CNT_ONE = 12'h001;
   // Arbitrary plain defaults for the mask-programmed register values
   localparam logic [CNT_W-1:0] DEF_H_MAX = 12'h38F;
   localparam logic [CNT_W-1:0] DEF_H_BLANK_END = 12'h0A0;
   localparam logic [CNT_W-1:0] DEF_H_DRV_START = 12'h010;
   localparam logic [CNT_W-1:0] DEF_H_DRV_END = 12'h050;
   localparam logic [CNT_W-1:0] DEF_V_MAX = 12'h20C;
   localparam logic [CNT_W-1:0] DEF_V_BLANK_END = 12'h014;
   localparam logic [CNT_W-1:0] DEF_V_DRV_START = 12'h003;
   localparam logic [CNT_W-1:0] DEF_V_DRV_END = 12'h006;
   localparam logic [STAT_W-1:0] DEF_STATUS = 16'h0000;
   // Register select codes of the internal write port
   localparam logic [2:0] SEL_STATUS = 3'h0;
   localparam logic [2:0] SEL_H_MAX = 3'h1;
   localparam logic [2:0] SEL_H_BLANK_END = 3'h2;
   localparam logic [2:0] SEL_H_DRV_START = 3'h3;
   localparam logic [2:0] SEL_H_DRV_END = 3'h4;
   localparam logic [2:0] SEL_V_MAX = 3'h5;
   localparam logic [2:0] SEL_V_DRV_START = 3'h6;
   localparam logic [2:0] SEL_V_DRV_END = 3'h7;
endpackage : vsrc_pkg

//--- vsrc_sync_gen.sv
`timescale 1ns/10ps
// Function
// (RULE_01) Clear loads defaults; clock-enable bit defaults off
// (RULE_02) Host sets enable bit before expecting sync
// (RULE_03) Restart keeps all programmed register contents
// (RULE_04) First frame after restart: drives start immediately
// (RULE_05) After first frame, drives use programmed times
// (RULE_06) Missed end time: count on to rollover
// (RULE_07) Host reprograms timing only during blanking
// (RULE_08) Restart applies new values, counters from start
// (RULE_09) Twelve-bit wrapping counters compared every enabled clock
module vsrc_sync_gen #(
   parameter logic [15:0] DEF_STATUS = vsrc_pkg::DEF_STATUS
) (
   input  wire logic                      core_clk,
   input  wire logic                      arst_n,
   input  wire logic                      clearPin,
   input  wire logic                      restartPin,
   input  wire logic                      wrStrobePin,
   input  wire logic [2:0]                wrSelPin,
   input  wire logic [vsrc_pkg::CNT_W-1:0] wrDataPin,
   output logic                           hDrive,
   output logic                           vDrive,
   output logic                           hBlank,
   output logic                           clkEnabled
);
   // Two-flop synchronisers; edge logic reads the second and third stages
   logic [2:0]                 clrSync_r;
   logic [2:0]                 rstSync_r;
   logic [2:0]                 wrSync_r;
   // Select and data pass two stages as well, ahead of the strobe
   logic [2:0]                 selA_r;
   logic [2:0]                 selB_r;
   logic [vsrc_pkg::CNT_W-1:0] datA_r;
   logic [vsrc_pkg::CNT_W-1:0] datB_r;

   // Clear pin; reset level matches the idle pin, so no false edge
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         clrSync_r <= 3'h0;
      end else begin
         clrSync_r <= {clrSync_r[1:0], clearPin};
      end
   end

   // Restart pin
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         rstSync_r <= 3'h0;
      end else begin
         rstSync_r <= {rstSync_r[1:0], restartPin};
      end
   end

   // Load strobe pin
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         wrSync_r <= 3'h0;
      end else begin
         wrSync_r <= {wrSync_r[1:0], wrStrobePin};
      end
   end

   // Select bus; must be steady at the clock edge that first samples the strobe high
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         selA_r <= 3'h0;
         selB_r <= 3'h0;
      end else begin
         selA_r <= wrSelPin;
         selB_r <= selA_r;
      end
   end

   // Data bus, same depth as the select bus
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         datA_r <= vsrc_pkg::CNT_ZERO;
         datB_r <= vsrc_pkg::CNT_ZERO;
      end else begin
         datA_r <= wrDataPin;
         datB_r <= datA_r;
      end
   end

   // Rising-edge pulses, one cycle each; third stage holds the old level
   logic                       clrPulse;
   logic                       rstPulse;
   logic                       wrPulse;
   assign clrPulse = clrSync_r[1] & ~clrSync_r[2];
   assign rstPulse = rstSync_r[1] & ~rstSync_r[2];
   assign wrPulse = wrSync_r[1] & ~wrSync_r[2];

   // Programmed registers
   logic [15:0] status_r;
   logic [vsrc_pkg::CNT_W-1:0] hMax_r, hBlankEnd_r, hDrvStart_r, hDrvEnd_r;
   logic [vsrc_pkg::CNT_W-1:0] vMax_r, vDrvStart_r, vDrvEnd_r;
   // Clear restores defaults; restart never touches these
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         status_r <= DEF_STATUS;
         hMax_r <= vsrc_pkg::DEF_H_MAX;
         hBlankEnd_r <= vsrc_pkg::DEF_H_BLANK_END;
         hDrvStart_r <= vsrc_pkg::DEF_H_DRV_START;
         hDrvEnd_r <= vsrc_pkg::DEF_H_DRV_END;
         vMax_r <= vsrc_pkg::DEF_V_MAX;
         vDrvStart_r <= vsrc_pkg::DEF_V_DRV_START;
         vDrvEnd_r <= vsrc_pkg::DEF_V_DRV_END;
      end else if (clrPulse) begin
         status_r <= DEF_STATUS; // RULE_01
         hMax_r <= vsrc_pkg::DEF_H_MAX;
         hBlankEnd_r <= vsrc_pkg::DEF_H_BLANK_END;
         hDrvStart_r <= vsrc_pkg::DEF_H_DRV_START;
         hDrvEnd_r <= vsrc_pkg::DEF_H_DRV_END;
         vMax_r <= vsrc_pkg::DEF_V_MAX;
         vDrvStart_r <= vsrc_pkg::DEF_V_DRV_START;
         vDrvEnd_r <= vsrc_pkg::DEF_V_DRV_END;
      end else if (wrPulse) begin
         unique case (selB_r)
            vsrc_pkg::SEL_STATUS: status_r <= {4'h0, datB_r};
            vsrc_pkg::SEL_H_MAX: hMax_r <= datB_r;
            vsrc_pkg::SEL_H_BLANK_END: hBlankEnd_r <= datB_r;
            vsrc_pkg::SEL_H_DRV_START: hDrvStart_r <= datB_r;
            vsrc_pkg::SEL_H_DRV_END: hDrvEnd_r <= datB_r;
            vsrc_pkg::SEL_V_MAX: vMax_r <= datB_r;
            vsrc_pkg::SEL_V_DRV_START: vDrvStart_r <= datB_r;
            vsrc_pkg::SEL_V_DRV_END: vDrvEnd_r <= datB_r;
         endcase
      end
   end

   logic enable;
   assign enable = status_r[vsrc_pkg::CLK_EN_BIT]; // RULE_02

   // Counters: equality compare only, so a missed end wraps at 4096
   logic [vsrc_pkg::CNT_W-1:0] hCnt_r;
   logic [vsrc_pkg::CNT_W-1:0] vCnt_r;
   logic                       hEnd;
   logic                       vEnd;
   assign hEnd = (hCnt_r == hMax_r); // RULE_06 RULE_09
   assign vEnd = (vCnt_r == vMax_r); // RULE_06

   // Line counter; restart and clear both return it to the first clock
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         hCnt_r <= vsrc_pkg::CNT_ZERO;
      end else if (rstPulse || clrPulse) begin
         hCnt_r <= vsrc_pkg::CNT_ZERO; // RULE_08
      end else if (enable) begin
         hCnt_r <= hEnd ? vsrc_pkg::CNT_ZERO : hCnt_r + vsrc_pkg::CNT_ONE; // RULE_09
      end
   end

   // Frame counter; steps once per line, only while counting is enabled
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         vCnt_r <= vsrc_pkg::CNT_ZERO;
      end else if (rstPulse || clrPulse) begin
         vCnt_r <= vsrc_pkg::CNT_ZERO; // RULE_08
      end else if (enable && hEnd) begin
         vCnt_r <= vEnd ? vsrc_pkg::CNT_ZERO : vCnt_r + vsrc_pkg::CNT_ONE; // RULE_09
      end
   end

   // First-frame flag after restart; cleared at frame end
   logic firstFrame_r;
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         firstFrame_r <= 1'b0;
      end else if (rstPulse) begin
         firstFrame_r <= 1'b1; // RULE_03 RULE_04
      end else if (clrPulse || (enable && hEnd && vEnd)) begin
         firstFrame_r <= 1'b0; // RULE_05
      end
   end

   // Drive start forced to count zero during the first frame
   logic [vsrc_pkg::CNT_W-1:0] hStart;
   logic [vsrc_pkg::CNT_W-1:0] vStart;
   assign hStart = firstFrame_r ? vsrc_pkg::CNT_ZERO : hDrvStart_r; // RULE_04
   assign vStart = firstFrame_r ? vsrc_pkg::CNT_ZERO : vDrvStart_r; // RULE_04 RULE_05

   // Window compares; the end compares stay as programmed throughout
   logic                       hInDrive;
   logic                       vInDrive;
   logic                       hInBlank;
   assign hInDrive = enable && (hCnt_r >= hStart) && (hCnt_r < hDrvEnd_r);
   assign vInDrive = enable && (vCnt_r >= vStart) && (vCnt_r < vDrvEnd_r);
   assign hInBlank = enable && (hCnt_r < hBlankEnd_r);

   // Horizontal drive, registered so the pin never glitches
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         hDrive <= 1'b0;
      end else begin
         hDrive <= hInDrive;
      end
   end

   // Vertical drive
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         vDrive <= 1'b0;
      end else begin
         vDrive <= vInDrive;
      end
   end

   // Horizontal blank
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         hBlank <= 1'b0;
      end else begin
         hBlank <= hInBlank;
      end
   end

   // Enable status mirrored on a pin, so the host sees when counting runs
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         clkEnabled <= 1'b0;
      end else begin
         clkEnabled <= enable;
      end
   end
endmodule : vsrc_sync_gen

//--- vsrc_sync_gen_monitor.sv
`timescale 1ns/10ps
module vsrc_sync_gen_check (
   input wire logic       core_clk,
   input wire logic       arst_n,
   input wire logic       clearPin,
   input wire logic       restartPin,
   input wire logic       wrStrobePin,
   input wire logic [2:0] wrSelPin,
   input wire logic [11:0] wrDataPin,
   input wire logic       hDrive,
   input wire logic       hBlank,
   input wire logic       clkEnabled
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!arst_n);
   // Pins act through a two-flop sync, so effects land within five edges
   rst_quiet_a: assert property ($rose(arst_n) |-> !hDrive && !clkEnabled)
      else $error("outputs not quiet after reset");
   clear_off_a: assert property ($rose(clearPin) |-> ##5 !clkEnabled)
      else $error("clear left clock enabled");
   halt_hold_a: assert property (!clkEnabled && $past(!clkEnabled) |-> $stable(hDrive))
      else $error("drive moved while halted");
   enable_wr_a: assert property ($rose(wrStrobePin) && wrSelPin == 3'h0
      |-> ##5 clkEnabled == $past(wrDataPin[10], 5)) else $error("enable bit not taken");
   keep_regs_a: assert property ($rose(restartPin) |-> ##5 clkEnabled == $past(clkEnabled, 5))
      else $error("restart changed status");
   first_drv_a: assert property ($rose(restartPin) && clkEnabled |-> ##[3:5] hDrive)
      else $error("no drive at restart");
   cnt_zero_a: assert property ($rose(restartPin) && clkEnabled |-> ##5 hBlank)
      else $error("counter not restarted");
endmodule : vsrc_sync_gen_check
bind vsrc_sync_gen vsrc_sync_gen_check vsrc_sync_gen_check_i (.core_clk(core_clk),
   .arst_n(arst_n), .clearPin(clearPin), .restartPin(restartPin), .wrStrobePin(wrStrobePin),
   .wrSelPin(wrSelPin), .wrDataPin(wrDataPin), .hDrive(hDrive), .hBlank(hBlank),
   .clkEnabled(clkEnabled));

//--- vsrc_display_model.sv
`timescale 1ns/10ps
module vsrc_display_model (
   input wire logic  core_clk,
   input wire logic  hDrive,
   output logic [12:0] pulseLen = 13'h0000,
   output logic [12:0] gapLen = 13'h0000
);
   logic [12:0] hiCnt = 13'h0000;
   logic [12:0] loCnt = 13'h0000;
   logic        prevDrv = 1'b0;
   // Monitor measures drive width and gap, as a sync input would see them
   always_ff @(posedge core_clk) begin
      prevDrv <= hDrive;
      if (hDrive) hiCnt <= hiCnt + 13'h0001;
      else loCnt <= loCnt + 13'h0001;
      if (!hDrive && prevDrv) begin
         pulseLen <= hiCnt;
         hiCnt <= 13'h0000;
      end
      if (hDrive && !prevDrv) begin
         gapLen <= loCnt;
         loCnt <= 13'h0000;
      end
   end
endmodule : vsrc_display_model

//--- video_sync_restart_control_test.sv
`timescale 1ns/10ps
module video_sync_restart_control_test;
   logic core_clk = 0, arst_n = 0, clearP = 0, restartP = 0, strobe = 0;
   logic [2:0] sel = 3'h0;
   logic [11:0] data = 12'h000, drvEnd;
   logic hDrive, vDrive, hBlank, clkEnabled;
   logic [12:0] pulseLen, gapLen;
   logic [31:0] seed = 32'h0001652D;
   logic [11:0] cfg[8] = '{12'h400, 12'h01F, 12'h008, 12'h004, 12'h00A, 12'h003, 12'h001, 12'h002};
   int fail_count = 0, tests_run = 0;
   always #12.5 core_clk = ~core_clk;
   vsrc_sync_gen vsrc_sync_gen_i (.core_clk(core_clk), .arst_n(arst_n), .clearPin(clearP),
      .restartPin(restartP), .wrStrobePin(strobe), .wrSelPin(sel), .wrDataPin(data),
      .hDrive(hDrive), .vDrive(vDrive), .hBlank(hBlank), .clkEnabled(clkEnabled));
   vsrc_display_model vsrc_display_model_i (.core_clk(core_clk), .hDrive(hDrive),
      .pulseLen(pulseLen), .gapLen(gapLen));
   function automatic logic [31:0] xs();
      seed ^= seed << 13; seed ^= seed >> 17; seed ^= seed << 5;
      return seed;
   endfunction : xs
   // Drive width: from zero in the first frame, from start afterwards
   function automatic logic [12:0] expLen(input logic first, input logic [11:0] e);
      return first ? {1'b0, e} : {1'b0, e - cfg[3]};
   endfunction : expLen
   task automatic chk(input string what, input logic [12:0] exp, input logic [12:0] got);
      tests_run++;
      if (got !== exp) begin
         fail_count++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   // Pins are slow levels; each phase held past the sync depth
   task automatic pin(ref logic p);
      p = 1'b1;
      repeat (4) @(negedge core_clk);
      p = 1'b0;
      repeat (4) @(negedge core_clk);
   endtask : pin
   task automatic wr(input logic [2:0] s, input logic [11:0] d);
      sel = s; data = d; repeat (3) @(negedge core_clk);
      pin(strobe);
   endtask : wr
   task automatic stop_test();
      $display("checks %0d mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : stop_test
   // Watchdog sized well beyond the longest rollover line
   initial begin
      repeat (20000) @(posedge core_clk);
      fail_count++;
      stop_test();
   end
   initial begin
      repeat (4) @(negedge core_clk);
      arst_n = 1;
      @(negedge core_clk);
      chk("enable at reset", 13'h0000, {12'h000, clkEnabled});
      for (int i = 1; i < 8; i++) wr(3'(i), cfg[i]);
      wr(3'h0, cfg[0]);
      chk("enable set", 13'h0001, {12'h000, clkEnabled});
      for (int n = 0; n < 3; n++) begin
         drvEnd = (n == 0) ? 12'h01E : 12'h005 + 12'(xs() % 26);
         cfg[4] = drvEnd;
         // Line timing rewritten only inside horizontal blanking
         @(posedge hBlank);
         @(negedge core_clk);
         wr(3'h4, drvEnd);
         pin(restartP);
         chk("first frame vdrive", 13'h0001, {12'h000, vDrive});
         repeat (70) @(negedge core_clk);
         chk("first frame width", expLen(1, drvEnd), pulseLen);
         repeat (200) @(negedge core_clk);
         chk("later width", expLen(0, drvEnd), pulseLen);
         chk("later vdrive", 13'h0000, {12'h000, vDrive});
      end
      // Shrinking the line end below the count forces a full wrap
      // Write lands well past count five, so the new end is missed
      @(negedge hBlank);
      @(negedge core_clk);
      wr(3'h1, 12'h005);
      for (int i = 0; i < 5000 && gapLen < 13'h0F00; i++) @(negedge core_clk);
      chk("overrun gap", 13'h0001, {12'h000, gapLen > 13'h0F00});
      pin(clearP);
      chk("enable after clear", 13'h0000, {12'h000, clkEnabled});
      stop_test();
   end
endmodule : video_sync_restart_control_test
